//--- tcl_defs.vh
// Constants of the text command-line front end: character codes,
// mnemonic codes, command numbers, status codes and config fields.
// Assumes inclusion by tcl_text_front.v and one of its two helper modules, the decimal formatter.
`ifndef TCL_DEFS_VH
`define TCL_DEFS_VH

// ----------------------------------------------------------------
// Characters
// ----------------------------------------------------------------
`define TCL_CH_CR      8'h0D
`define TCL_CH_BS      8'h08
`define TCL_CH_SP      8'h20
`define TCL_CH_COMMA   8'h2C
`define TCL_CH_MINUS   8'h2D
`define TCL_CH_ZERO    8'h30
`define TCL_LETTER_OFS 8'h40

// ----------------------------------------------------------------
// Mnemonics, right aligned ASCII
// ----------------------------------------------------------------
`define TCL_MN_ROR  32'h00524F52
`define TCL_MN_ROL  32'h00524F4C
`define TCL_MN_MST  32'h004D5354
`define TCL_MN_MVP  32'h004D5650
`define TCL_MN_SAP  32'h00534150
`define TCL_MN_GAP  32'h00474150
`define TCL_MN_STAP 32'h53544150
`define TCL_MN_RSAP 32'h52534150
`define TCL_MN_SGP  32'h00534750
`define TCL_MN_GGP  32'h00474750
`define TCL_MN_STGP 32'h53544750
`define TCL_MN_RSGP 32'h52534750
`define TCL_MN_RFS  32'h00524653
`define TCL_MN_SIO  32'h0053494F
`define TCL_MN_GIO  32'h0047494F
`define TCL_MN_SCO  32'h0053434F
`define TCL_MN_GCO  32'h0047434F
`define TCL_MN_CCO  32'h0043434F
`define TCL_MN_UF   16'h5546
`define TCL_MN_BIN  32'h0042494E
`define TCL_MN_RUN  32'h0052554E
`define TCL_MN_STOP 32'h53544F50

// ----------------------------------------------------------------
// Command numbers and status codes
// ----------------------------------------------------------------
`define TCL_CMD_ENTER_TEXT 8'h8B
`define TCL_CMD_SCO        8'h1E
`define TCL_CMD_UF0        8'h40
`define TCL_ST_OK          8'h64
`define TCL_ST_INVALID     8'h02
`define TCL_FRAME_LAST     4'h8

// ----------------------------------------------------------------
// Config register fields and sizes
// ----------------------------------------------------------------
`define TCL_CFG_TEXT_BIT 0
`define TCL_CFG_ECHO_LO  4
`define TCL_CFG_ECHO_HI  5
`define TCL_LINE_DEPTH   32
`define TCL_LINE_AW      5

`endif

//--- tcl_buf2.v
// Two-entry byte buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module tcl_buf2 #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem0_reg;
	reg [W-1:0] mem1_reg;
	reg [1:0]   cnt_reg;
	reg         rd_reg;
	reg         wr_reg;
	wire        push;
	wire        pop;

	assign in_ready  = (cnt_reg != 2'd2);
	assign out_valid = (cnt_reg != 2'd0);
	assign out_data  = rd_reg ? mem1_reg : mem0_reg;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and fill bookkeeping
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			mem0_reg <= {W{1'b0}};
			mem1_reg <= {W{1'b0}};
			cnt_reg  <= 2'd0;
			rd_reg   <= 1'b0;
			wr_reg   <= 1'b0;
		end
		else
		begin
			if (push && !wr_reg)
				mem0_reg <= in_data;
			if (push && wr_reg)
				mem1_reg <= in_data;
			if (push)
				wr_reg <= ~wr_reg;
			if (pop)
				rd_reg <= ~rd_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // tcl_buf2

//--- tcl_dec_fmt.v
// Signed 32-bit to decimal text, one character per handshake.
// Assumes start is only pulsed while busy is low.
`timescale 1ns/10ps
`include "tcl_defs.vh"
module tcl_dec_fmt (
	input  wire        clk,
	input  wire        rstn,
	input  wire        start,
	input  wire [31:0] value,
	output wire        busy,
	output wire        ch_valid,
	input  wire        ch_ready,
	output wire [7:0]  ch_data
);
	reg        busy_reg;
	reg        neg_reg;
	reg        seen_reg;
	reg [31:0] rem_reg;
	reg [3:0]  pidx_reg;
	reg [3:0]  dig_reg;
	reg [31:0] pw;
	wire       ge;
	wire       show;

	// Power of ten for the current digit position
	always @*
	begin
		case (pidx_reg)
			4'd0: pw = 32'h3B9ACA00;
			4'd1: pw = 32'h05F5E100;
			4'd2: pw = 32'h00989680;
			4'd3: pw = 32'h000F4240;
			4'd4: pw = 32'h000186A0;
			4'd5: pw = 32'h00002710;
			4'd6: pw = 32'h000003E8;
			4'd7: pw = 32'h00000064;
			4'd8: pw = 32'h0000000A;
			default: pw = 32'h00000001;
		endcase
	end

	assign ge       = (rem_reg >= pw);
	assign show     = neg_reg | seen_reg | (dig_reg != 4'd0) |
	                  (pidx_reg == 4'd9);
	assign busy     = busy_reg;
	assign ch_valid = busy_reg & (neg_reg | (!ge & show));
	assign ch_data  = neg_reg ? `TCL_CH_MINUS :
	                  (`TCL_CH_ZERO + {4'h0, dig_reg});

	// Repeated subtraction, leading zeros suppressed
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			busy_reg <= 1'b0;
			neg_reg  <= 1'b0;
			seen_reg <= 1'b0;
			rem_reg  <= 32'h00000000;
			pidx_reg <= 4'd0;
			dig_reg  <= 4'd0;
		end
		else if (start)
		begin
			busy_reg <= 1'b1;
			neg_reg  <= value[31];
			seen_reg <= 1'b0;
			rem_reg  <= value[31] ? (~value + 32'h00000001) : value;
			pidx_reg <= 4'd0;
			dig_reg  <= 4'd0;
		end
		else if (busy_reg)
		begin
			if (neg_reg)
			begin
				if (ch_ready)
					neg_reg <= 1'b0;
			end
			else if (ge)
			begin
				rem_reg <= rem_reg - pw;
				dig_reg <= dig_reg + 4'd1;
			end
			else if (!show || ch_ready)
			begin
				seen_reg <= show;
				dig_reg  <= 4'd0;
				pidx_reg <= pidx_reg + 4'd1;
				if (pidx_reg == 4'd9)
					busy_reg <= 1'b0;
			end
		end
	end
endmodule // tcl_dec_fmt

//--- tcl_text_front.v
// Text command-line front end: binary frame watch, line entry with
// echo, parser, command dispatch and decimal text reply.
// Assumes one 200 MHz clock; rx and execution ports are synchronous.
`timescale 1ns/10ps
`include "tcl_defs.vh"
module tcl_text_front (
	input  wire        clk,
	input  wire        rstn,
	input  wire [7:0]  cfg_init,
	input  wire        cfg_wr,
	input  wire [7:0]  cfg_wdata,
	output wire [7:0]  cfg_rdata,
	input  wire [7:0]  mod_addr,
	input  wire [7:0]  host_addr,
	input  wire        rx_valid,
	output wire        rx_ready,
	input  wire [7:0]  rx_data,
	output wire        tx_valid,
	input  wire        tx_ready,
	output wire [7:0]  tx_data,
	output wire        bin_valid,
	output wire [7:0]  bin_data,
	output wire        text_mode,
	output wire        exe_valid,
	output wire [7:0]  exe_cmd,
	output wire [7:0]  exe_type,
	output wire [7:0]  exe_motor,
	output wire [31:0] exe_value,
	input  wire        exe_done,
	input  wire [7:0]  exe_status,
	input  wire [31:0] exe_result,
	output wire        prog_run,
	output wire        prog_stop
);
	localparam S_INIT  = 3'd0;
	localparam S_BIN   = 3'd1;
	localparam S_COLL  = 3'd2;
	localparam S_ECHO  = 3'd3;
	localparam S_PARSE = 3'd4;
	localparam S_EXEC  = 3'd5;
	localparam S_REPLY = 3'd6;

	reg [2:0]  st_reg;
	reg [7:0]  cfg_reg;
	reg [7:0]  line_reg [0:`TCL_LINE_DEPTH-1];
	reg [5:0]  cnt_reg;
	reg [5:0]  idx_reg;
	reg        addr_hit_reg;
	reg        ovf_reg;
	reg [3:0]  fcnt_reg;
	reg [7:0]  fsum_reg;
	reg [7:0]  faddr_reg;
	reg [7:0]  fcmd_reg;
	reg        bin_valid_reg;
	reg [7:0]  bin_data_reg;
	reg [1:0]  ps_reg;
	reg [31:0] mn_reg;
	reg [2:0]  mn_len_reg;
	reg [31:0] acc_reg;
	reg        neg_reg;
	reg        innum_reg;
	reg        kw_reg;
	reg [1:0]  pcnt_reg;
	reg        perr_reg;
	reg [31:0] p0_reg;
	reg [31:0] p1_reg;
	reg [31:0] p2_reg;
	reg        exe_valid_reg;
	reg [7:0]  exe_cmd_reg;
	reg [7:0]  exe_type_reg;
	reg [7:0]  exe_motor_reg;
	reg [31:0] exe_value_reg;
	reg [7:0]  rst_code_reg;
	reg [31:0] rval_reg;
	reg [3:0]  rp_reg;
	reg        leave_reg;
	reg        run_reg;
	reg        stop_reg;
	reg        emit_valid;
	reg [7:0]  emit_data;
	reg [9:0]  look;
	wire       emit_ready;
	wire       dec_busy;
	wire       dec_valid;
	wire [7:0] dec_data;
	wire       dec_start;
	wire       rx_fire;
	wire [7:0] my_letter;
	wire [7:0] c;
	wire       is_letter;
	wire       is_digit;
	wire       echo_imm;
	wire       echo_line;
	wire       first_hit;
	wire [31:0] acc_x10;
	wire [31:0] acc_sgn;
	wire [5:0]  cnt_dec;

	assign my_letter = `TCL_LETTER_OFS + mod_addr;
	assign echo_imm  = !cfg_reg[`TCL_CFG_ECHO_LO] &&
	                   !cfg_reg[`TCL_CFG_ECHO_HI];
	assign echo_line = cfg_reg[`TCL_CFG_ECHO_LO] &&
	                   !cfg_reg[`TCL_CFG_ECHO_HI];
	assign rx_ready  = (st_reg == S_BIN) ||
	                   ((st_reg == S_COLL) && emit_ready);
	assign rx_fire   = rx_valid & rx_ready;
	assign first_hit = (cnt_reg == 6'd0) && (rx_data == my_letter);
	assign c         = line_reg[idx_reg[4:0]];
	assign is_letter = (c >= 8'h41) && (c <= 8'h5A);
	assign is_digit  = (c >= 8'h30) && (c <= 8'h39);
	assign acc_x10   = {acc_reg[28:0], 3'b000} + {acc_reg[30:0], 1'b0};
	assign acc_sgn   = neg_reg ? (~acc_reg + 32'h00000001) : acc_reg;
	assign cnt_dec   = cnt_reg - 6'd1;
	assign dec_start = (st_reg == S_REPLY) &&
	                   ((rp_reg == 4'd3) || (rp_reg == 4'd6));
	assign cfg_rdata = cfg_reg;
	assign text_mode = (st_reg != S_BIN) && (st_reg != S_INIT);
	assign bin_valid = bin_valid_reg;
	assign bin_data  = bin_data_reg;
	assign exe_valid = exe_valid_reg;
	assign exe_cmd   = exe_cmd_reg;
	assign exe_type  = exe_type_reg;
	assign exe_motor = exe_motor_reg;
	assign exe_value = exe_value_reg;
	assign prog_run  = run_reg;
	assign prog_stop = stop_reg;

	// ------------------------------------------------------------
	// Accepted command table: {ok, motor first, command number}
	// ------------------------------------------------------------
	always @*
	begin
		look = 10'h000;
		case (mn_reg)
			`TCL_MN_ROR:  look = 10'h301;
			`TCL_MN_ROL:  look = 10'h302;
			`TCL_MN_MST:  look = 10'h303;
			`TCL_MN_MVP:  look = 10'h204;
			`TCL_MN_SAP:  look = 10'h205;
			`TCL_MN_GAP:  look = 10'h206;
			`TCL_MN_STAP: look = 10'h207;
			`TCL_MN_RSAP: look = 10'h208;
			`TCL_MN_SGP:  look = 10'h209;
			`TCL_MN_GGP:  look = 10'h20A;
			`TCL_MN_STGP: look = 10'h20B;
			`TCL_MN_RSGP: look = 10'h20C;
			`TCL_MN_RFS:  look = 10'h20D;
			`TCL_MN_SIO:  look = 10'h20E;
			`TCL_MN_GIO:  look = 10'h20F;
			`TCL_MN_SCO:  look = 10'h21E;
			`TCL_MN_GCO:  look = 10'h21F;
			`TCL_MN_CCO:  look = 10'h220;
			default:
			begin
				if (mn_reg[31:8] == {8'h00, `TCL_MN_UF} &&
				    mn_reg[7:0] >= 8'h30 && mn_reg[7:0] <= 8'h37)
					look = {2'b10, `TCL_CMD_UF0 + mn_reg[7:0] - 8'h30};
			end
		endcase
	end

	// ------------------------------------------------------------
	// Byte source for the transmit buffer
	// ------------------------------------------------------------
	always @*
	begin
		emit_valid = 1'b0;
		emit_data  = rx_data;
		case (st_reg)
			S_COLL:
			begin
				// Echo only lines for this module, immediate mode
				emit_valid = rx_fire && echo_imm &&
				             (addr_hit_reg || first_hit);
			end
			S_ECHO:
			begin
				emit_valid = 1'b1;
				emit_data  = (idx_reg == cnt_reg) ? `TCL_CH_CR : c;
			end
			S_REPLY:
			begin
				emit_valid = 1'b1;
				case (rp_reg)
					4'd0: emit_data = `TCL_LETTER_OFS + host_addr;
					4'd1: emit_data = my_letter;
					4'd2: emit_data = `TCL_CH_SP;
					4'd5: emit_data = `TCL_CH_SP;
					4'd8: emit_data = `TCL_CH_CR;
					4'd4, 4'd7:
					begin
						emit_valid = dec_valid;
						emit_data  = dec_data;
					end
					default: emit_valid = 1'b0;
				endcase
			end
			default: emit_valid = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Line storage, written only while collecting
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (st_reg == S_COLL && rx_fire && cnt_reg < `TCL_LINE_DEPTH)
			line_reg[cnt_reg[4:0]] <= rx_data;
	end

	// ------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			st_reg <= S_INIT;       cfg_reg <= 8'h00;
			cnt_reg <= 6'd0;        idx_reg <= 6'd0;
			addr_hit_reg <= 1'b0;   ovf_reg <= 1'b0;
			fcnt_reg <= 4'd0;       fsum_reg <= 8'h00;
			faddr_reg <= 8'h00;     fcmd_reg <= 8'h00;
			bin_valid_reg <= 1'b0;  bin_data_reg <= 8'h00;
			ps_reg <= 2'd0;         mn_reg <= 32'h00000000;
			mn_len_reg <= 3'd0;     acc_reg <= 32'h00000000;
			neg_reg <= 1'b0;        innum_reg <= 1'b0;
			kw_reg <= 1'b0;         pcnt_reg <= 2'd0;
			perr_reg <= 1'b0;       p0_reg <= 32'h00000000;
			p1_reg <= 32'h00000000; p2_reg <= 32'h00000000;
			exe_valid_reg <= 1'b0;  exe_cmd_reg <= 8'h00;
			exe_type_reg <= 8'h00;  exe_motor_reg <= 8'h00;
			exe_value_reg <= 32'h00000000;
			rst_code_reg <= 8'h00;  rval_reg <= 32'h00000000;
			rp_reg <= 4'd0;         leave_reg <= 1'b0;
			run_reg <= 1'b0;        stop_reg <= 1'b0;
		end
		else
		begin
			run_reg <= 1'b0;
			stop_reg <= 1'b0;
			bin_valid_reg <= 1'b0;
			if (cfg_wr)
				cfg_reg <= cfg_wdata;
			case (st_reg)
				S_INIT:
				begin
					// Stored setting picks the startup mode
					cfg_reg <= cfg_init;
					st_reg  <= cfg_init[`TCL_CFG_TEXT_BIT] ?
					           S_COLL : S_BIN;
				end
				S_BIN:
				begin
					if (rx_fire)
					begin
						bin_valid_reg <= 1'b1;
						bin_data_reg  <= rx_data;
						fsum_reg <= fsum_reg + rx_data;
						fcnt_reg <= fcnt_reg + 4'd1;
						if (fcnt_reg == 4'd0)
							faddr_reg <= rx_data;
						if (fcnt_reg == 4'd1)
							fcmd_reg <= rx_data;
						if (fcnt_reg == `TCL_FRAME_LAST)
						begin
							fcnt_reg <= 4'd0;
							fsum_reg <= 8'h00;
							if (fsum_reg == rx_data &&
							    faddr_reg == mod_addr &&
							    fcmd_reg == `TCL_CMD_ENTER_TEXT)
								st_reg <= S_COLL;
						end
					end
				end
				S_COLL:
				begin
					if (rx_fire)
					begin
						if (rx_data == `TCL_CH_CR)
						begin
							idx_reg <= 6'd0;
							ovf_reg <= addr_hit_reg & ovf_reg;
							if (!addr_hit_reg)
								cnt_reg <= 6'd0;
							else
								st_reg <= echo_line ? S_ECHO : S_PARSE;
						end
						else if (rx_data == `TCL_CH_BS)
						begin
							if (cnt_reg != 6'd0)
								cnt_reg <= cnt_dec;
							if (cnt_reg == 6'd1)
								addr_hit_reg <= 1'b0;
						end
						else if (cnt_reg < `TCL_LINE_DEPTH)
						begin
							cnt_reg <= cnt_reg + 6'd1;
							if (cnt_reg == 6'd0)
								addr_hit_reg <= first_hit;
						end
						else
							ovf_reg <= 1'b1;
					end
				end
				S_ECHO:
				begin
					if (emit_ready)
					begin
						idx_reg <= idx_reg + 6'd1;
						if (idx_reg == cnt_reg)
						begin
							idx_reg <= 6'd1;
							st_reg  <= S_PARSE;
						end
					end
				end
				S_PARSE:
				begin
					if (idx_reg == 6'd0)
						idx_reg <= 6'd1;
					else if (idx_reg < cnt_reg)
					begin
						idx_reg <= idx_reg + 6'd1;
						case (ps_reg)
							2'd0:
							begin
								if (is_letter)
								begin
									mn_reg <= {24'h000000, c};
									mn_len_reg <= 3'd1;
									ps_reg <= 2'd1;
								end
								else if (c != `TCL_CH_SP)
									perr_reg <= 1'b1;
							end
							2'd1:
							begin
								if (c == `TCL_CH_SP)
									ps_reg <= 2'd2;
								else if ((is_letter || is_digit) &&
								         mn_len_reg != 3'd4)
								begin
									mn_reg <= {mn_reg[23:0], c};
									mn_len_reg <= mn_len_reg + 3'd1;
								end
								else
									perr_reg <= 1'b1;
							end
							default:
							begin
								// Numbers and ABS/REL/COORD words
								if (c == `TCL_CH_SP || c == `TCL_CH_COMMA)
								begin
									if (innum_reg)
									begin
										if (pcnt_reg == 2'd0) p0_reg <= acc_sgn;
										if (pcnt_reg == 2'd1) p1_reg <= acc_sgn;
										if (pcnt_reg == 2'd2) p2_reg <= acc_sgn;
										if (pcnt_reg == 2'd3) perr_reg <= 1'b1;
										pcnt_reg <= pcnt_reg + 2'd1;
									end
									innum_reg <= 1'b0;
									kw_reg <= 1'b0;
									neg_reg <= 1'b0;
									acc_reg <= 32'h00000000;
								end
								else if (c == `TCL_CH_MINUS && !innum_reg)
								begin
									neg_reg <= 1'b1;
									innum_reg <= 1'b1;
								end
								else if (is_digit && !kw_reg)
								begin
									acc_reg <= acc_x10 + {24'h000000,
									           c - `TCL_CH_ZERO};
									innum_reg <= 1'b1;
								end
								else if (is_letter && !innum_reg)
								begin
									innum_reg <= 1'b1;
									kw_reg <= 1'b1;
									acc_reg <= (c == 8'h52) ? 32'h00000001 :
									           (c == 8'h43) ? 32'h00000002 :
									           32'h00000000;
								end
								else if (!(is_letter && kw_reg))
									perr_reg <= 1'b1;
							end
						endcase
					end
					else
					begin
						// Close last number, then dispatch
						if (innum_reg)
						begin
							if (pcnt_reg == 2'd0) p0_reg <= acc_sgn;
							if (pcnt_reg == 2'd1) p1_reg <= acc_sgn;
							if (pcnt_reg == 2'd2) p2_reg <= acc_sgn;
							if (pcnt_reg == 2'd3) perr_reg <= 1'b1;
							innum_reg <= 1'b0;
						end
						else
						begin
							rst_code_reg <= `TCL_ST_OK;
							rval_reg <= 32'h00000000;
							rp_reg <= 4'd0;
							st_reg <= S_REPLY;
							if (perr_reg || ovf_reg)
								rst_code_reg <= `TCL_ST_INVALID;
							else if (mn_reg == `TCL_MN_BIN)
								leave_reg <= 1'b1;
							else if (mn_reg == `TCL_MN_RUN)
								run_reg <= 1'b1;
							else if (mn_reg == `TCL_MN_STOP)
								stop_reg <= 1'b1;
							else if (look[9])
							begin
								exe_valid_reg <= 1'b1;
								exe_cmd_reg <= look[7:0];
								exe_type_reg <= look[8] ? 8'h00 : p0_reg[7:0];
								exe_motor_reg <= look[8] ? p0_reg[7:0] :
								                 p1_reg[7:0];
								exe_value_reg <= look[8] ? p1_reg : p2_reg;
								st_reg <= S_EXEC;
							end
							else
								rst_code_reg <= `TCL_ST_INVALID;
						end
					end
				end
				S_EXEC:
				begin
					if (exe_done)
					begin
						exe_valid_reg <= 1'b0;
						rst_code_reg <= exe_status;
						rval_reg <= exe_result;
						st_reg <= S_REPLY;
					end
				end
				S_REPLY:
				begin
					// Fixed characters wait for room, digits for done
					if ((rp_reg == 4'd3) || (rp_reg == 4'd6) ||
					    (((rp_reg == 4'd4) || (rp_reg == 4'd7)) &&
					     !dec_busy) ||
					    (emit_valid && emit_ready &&
					     rp_reg != 4'd4 && rp_reg != 4'd7))
						rp_reg <= rp_reg + 4'd1;
					if (rp_reg == 4'd8 && emit_ready)
					begin
						st_reg <= leave_reg ? S_BIN : S_COLL;
						leave_reg <= 1'b0;
						cnt_reg <= 6'd0;
						idx_reg <= 6'd0;
						addr_hit_reg <= 1'b0;
						ovf_reg <= 1'b0;
						ps_reg <= 2'd0;
						mn_reg <= 32'h00000000;
						perr_reg <= 1'b0;
						pcnt_reg <= 2'd0;
						acc_reg <= 32'h00000000;
						neg_reg <= 1'b0;
						kw_reg <= 1'b0;
						p0_reg <= 32'h00000000;
						p1_reg <= 32'h00000000;
						p2_reg <= 32'h00000000;
						fcnt_reg <= 4'd0;
						fsum_reg <= 8'h00;
					end
				end
				default: st_reg <= S_INIT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Decimal formatter and transmit buffer
	// ------------------------------------------------------------
	tcl_dec_fmt u_dec (
		.clk      (clk),
		.rstn     (rstn),
		.start    (dec_start),
		.value    ((rp_reg == 4'd3) ? {24'h000000, rst_code_reg} :
		           rval_reg),
		.busy     (dec_busy),
		.ch_valid (dec_valid),
		.ch_ready (emit_ready && (st_reg == S_REPLY)),
		.ch_data  (dec_data)
	);

	tcl_buf2 #(.W(8)) u_buf (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (emit_valid),
		.in_ready  (emit_ready),
		.in_data   (emit_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);
endmodule // tcl_text_front

//--- tcl_text_monitor.sv
// Checker for the text front end, watching its ports only.
// Assumes a bind to tcl_text_front and its single clock.
`timescale 1ns/10ps
module tcl_text_monitor (
	input wire       clk,
	input wire       rstn,
	input wire       cfg_wr,
	input wire [7:0] cfg_wdata,
	input wire [7:0] cfg_rdata,
	input wire       rx_valid,
	input wire       rx_ready,
	input wire [7:0] rx_data,
	input wire       tx_valid,
	input wire       tx_ready,
	input wire [7:0] tx_data,
	input wire       bin_valid,
	input wire [7:0] bin_data,
	input wire       text_mode,
	input wire       exe_valid,
	input wire       exe_done,
	input wire [7:0] exe_cmd,
	input wire       prog_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte left before taken");
	a_exe_hold: assert property (
		exe_valid && !exe_done |=> exe_valid && $stable(exe_cmd))
		else $error("request dropped early");
	a_exe_drop: assert property (
		exe_valid && exe_done |=> !exe_valid)
		else $error("request held after done");
	a_rst_quiet: assert property (disable iff (1'b0)
		!rstn |=> !tx_valid && !exe_valid && !rx_ready && !bin_valid)
		else $error("output active in reset");
	a_bin_pass: assert property (
		!text_mode && rx_valid && rx_ready |=>
		bin_valid && bin_data == $past(rx_data))
		else $error("binary byte not passed on");
	a_prog_text: assert property (
		prog_run |-> text_mode ##1 !prog_run)
		else $error("run pulse wrong");
	a_cfg_write: assert property (
		$past(rstn) && cfg_wr |=> cfg_rdata == $past(cfg_wdata))
		else $error("config write lost");
	a_exe_text: assert property (
		exe_valid |-> text_mode)
		else $error("request outside text mode");
	c_exe: cover property (exe_valid && exe_done);
	c_run: cover property (prog_run);
	c_stall: cover property (tx_valid && !tx_ready);
endmodule // tcl_text_monitor

bind tcl_text_front tcl_text_monitor mon_u (.clk(clk), .rstn(rstn),
	.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
	.bin_valid(bin_valid), .bin_data(bin_data), .text_mode(text_mode),
	.exe_valid(exe_valid), .exe_done(exe_done), .exe_cmd(exe_cmd),
	.prog_run(prog_run));

//--- tcl_host_model.sv
// Host terminal stand-in on the rx and tx byte streams.
// Assumes put and idle are called just after a clock edge.
`timescale 1ns/10ps
module tcl_host_model (
	input  wire       clk,
	output reg        rx_valid,
	input  wire       rx_ready,
	output reg  [7:0] rx_data,
	input  wire       tx_valid,
	output reg        tx_ready,
	input  wire [7:0] tx_data
);
	reg   [2:0] stall_cnt = 3'h0;
	logic [7:0] got[$];
	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
		tx_ready = 1'b0;
	end
	// Byte held until the edge that takes it
	task put(input [7:0] b);
	begin
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk iff rx_ready === 1'b1);
	end
	endtask
	// Released line shows the inverse byte
	task idle;
	begin
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	end
	endtask
	// Reader stalls four cycles out of eight
	always @(posedge clk)
	begin
		stall_cnt <= stall_cnt + 3'h1;
		tx_ready <= stall_cnt[2];
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule // tcl_host_model

//--- tcl_text_front_tb.sv
// Self-checking bench for the text command-line front end.
// Assumes the host model and the bound checker compile with it.
`timescale 1ns/10ps
module tcl_text_front_tb;
	reg         clk = 1'b0;
	reg         rstn = 1'b0;
	reg  [7:0]  cfg_init = 8'h00;
	reg         cfg_wr = 1'b0;
	reg  [7:0]  cfg_wdata = 8'h00;
	reg         exe_done = 1'b0;
	reg  [7:0]  exe_st = 8'h64;
	reg  [31:0] exe_result = 32'h0;
	reg  [55:0] req = 56'h0;
	reg  [2:0]  wait_cnt = 3'h0;
	reg  [31:0] rnd;
	reg  [31:0] m;
	integer     n_exe = 0, n_run = 0, n_stop = 0;
	integer     failures = 0, checks = 0, cycles = 0;
	string      s;
	wire        rx_valid, rx_ready, tx_valid, tx_ready, text_mode;
	wire        exe_valid, prog_run, prog_stop;
	wire [7:0]  rx_data, tx_data, cfg_rdata, exe_cmd, exe_type, exe_motor;
	wire [31:0] exe_value;

	tcl_text_front dut_u (.clk(clk), .rstn(rstn), .cfg_init(cfg_init),
		.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.mod_addr(8'h01), .host_addr(8'h02), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .bin_valid(), .bin_data(),
		.text_mode(text_mode), .exe_valid(exe_valid), .exe_cmd(exe_cmd),
		.exe_type(exe_type), .exe_motor(exe_motor), .exe_value(exe_value),
		.exe_done(exe_done), .exe_status(exe_st), .exe_result(exe_result),
		.prog_run(prog_run), .prog_stop(prog_stop));
	tcl_host_model host_u (.clk(clk), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data));

	always #2.5 clk = ~clk;

	function [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function string rep(input [7:0] st, input [31:0] v);
		rep = $sformatf("BA %0d %0d\015", st, $signed(v));
	endfunction

	task check(input string what, input [63:0] seen, input [63:0] exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	end
	endtask

	task finish_test;
	begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	task line(input string t, input string exp);
		integer i;
	begin
		host_u.got.delete();
		for (i = 0; i < t.len(); i = i + 1)
			host_u.put(t[i]);
		host_u.idle();
		for (i = 0; i < 900 && host_u.got.size() < exp.len(); i = i + 1)
			@(posedge clk);
		repeat (40) @(posedge clk);
		check("tx count", host_u.got.size(), exp.len());
		for (i = 0; i < exp.len() && i < host_u.got.size(); i = i + 1)
			check("tx byte", host_u.got[i], exp[i]);
		$display("line test done");
	end
	endtask

	task frame(input [7:0] sum);
		integer i;
		reg [71:0] f;
	begin
		f = {8'h01, 8'h8B, 48'h0, sum};
		for (i = 8; i >= 0; i = i - 1)
			host_u.put(f[i*8 +: 8]);
		host_u.idle();
		repeat (4) @(posedge clk);
	end
	endtask

	task cfg(input [7:0] v);
	begin
		cfg_wdata <= v;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		@(posedge clk);
		check("config", cfg_rdata, v);
	end
	endtask

	// Executor stand-in, timeout and pulse counts
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		exe_done <= 1'b0;
		if (prog_run === 1'b1)
			n_run <= n_run + 1;
		if (prog_stop === 1'b1)
			n_stop <= n_stop + 1;
		if (exe_valid === 1'b1 && !exe_done)
			wait_cnt <= wait_cnt + 3'h1;
		if (wait_cnt == 3'h3)
		begin
			wait_cnt <= 3'h0;
			exe_done <= 1'b1;
			req <= {exe_cmd, exe_type, exe_motor, exe_value};
			n_exe <= n_exe + 1;
		end
		if (cycles == 20000)
		begin
			failures = failures + 1;
			finish_test;
		end
	end

	// Main sequence
	initial
	begin
		rnd = 32'hEEBEEA64;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		check("boot", text_mode, 64'h0);
		frame(8'h8D);
		check("bad sum", text_mode, 64'h0);
		frame(8'h8C);
		check("enter", text_mode, 64'h1);
		rnd = lfsr(rnd);
		exe_result <= rnd;
		s = "A  GAP 9\0100, 1\015";
		line(s, {s, rep(8'h64, rnd)});
		check("gap", req, {8'h06, 8'h00, 8'h01, 32'h0});
		line("BGAP 0, 1\015", "");
		cfg(8'h10);
		rnd = lfsr(rnd);
		exe_result <= rnd;
		s = $sformatf("AROL 2, %0d\015", rnd[15:0]);
		line(s, {s, rep(8'h64, rnd)});
		check("rol", req, {24'h020002, 16'h0, rnd[15:0]});
		cfg(8'h20);
		rnd = lfsr(rnd);
		exe_result <= rnd;
		exe_st <= 8'h04;
		m = -{12'h0, rnd[19:0]};
		s = $sformatf("AMVP ABS, 1, %0d\015", $signed(m));
		line(s, rep(8'h04, rnd));
		check("mvp", req, {24'h040001, m});
		line("AUF3 1, 2, 3\015", rep(8'h04, rnd));
		check("uf", req, {24'h430102, 32'h3});
		line("ARUN\015", rep(8'h64, 32'h0));
		line("ASTOP\015", rep(8'h64, 32'h0));
		check("run stop", {n_run[3:0], n_stop[3:0]}, 64'h11);
		line("AJA 5\015", rep(8'h02, 32'h0));
		check("exe count", n_exe, 64'h4);
		line("ABIN\015", rep(8'h64, 32'h0));
		check("leave", text_mode, 64'h0);
		rstn <= 1'b0;
		cfg_init <= 8'h01;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		check("boot text", {text_mode, cfg_rdata}, 64'h101);
		finish_test;
	end
endmodule // tcl_text_front_tb
